// file: hpf_pkg.sv
// Constants for the host port flow and reset block
package hpf_pkg;
	localparam int          DATA_W       = 8;
	localparam int          FIFO_DEPTH   = 8;
	localparam int          CLK_MHZ      = 200;
	localparam int          BAUD_DIV     = 1736;
	localparam int          SPI_DIV      = 50;
	localparam logic        TXD_IDLE     = 1'b1;
	localparam logic        SS_IDLE_N    = 1'b1;
	localparam logic        LOCK_ON_N    = 1'b0;
	localparam logic [1:0]  SLP_LOW      = 2'h0;
	localparam logic [1:0]  SLP_HIGH     = 2'h1;
	localparam logic [1:0]  SLP_TRI      = 2'h2;
	localparam logic [1:0]  SLP_ACTIVE   = 2'h3;
	localparam int          SYNC_STAGES  = 3;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} hpf_tx_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} hpf_rx_t;
endpackage : hpf_pkg

// file: hpf_fifo.sv
// Parameterised valid/ready FIFO for the receive data path
`timescale 1ns/1ps
module hpf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	initial
	begin
		if (DEPTH < 2 || WIDTH < 1)
			$error("hpf_fifo: bad depth or width");
	end

	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
	endfunction

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= bump(wr_reg);
			if (pop)
				rd_reg <= bump(rd_reg);
			if (push && !pop)
				cnt_reg <= cnt_reg + (AW+1)'(1);
			else if (pop && !push)
				cnt_reg <= cnt_reg - (AW+1)'(1);
		end
	end
endmodule // hpf_fifo

// file: hpf_host_port.sv
// Host port: UART with flow control, SPI pin roles, sleep pin states
//
// Functional notes
// - Send permission high holds off new module bytes
// - Accept-ready low when module takes data
// - Transmit on serial out, receive serial in
// - Serial output sleep state is configurable
// - Accept-ready and lock share sleep state
// - Master drives SS, MOSI, SCLK; slave inputs
// - MISO input as master, output as slave
// - Active low hardware reset clears all but the input sync flops
// - Lock indicator low when locked/connected
`timescale 1ns/1ps
module hpf_host_port
	import hpf_pkg::*;
#(
	parameter int BAUD_CYC = hpf_pkg::BAUD_DIV,
	parameter int SPI_HALF = hpf_pkg::SPI_DIV
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       ce,
	input  wire logic                       reset_in_n,
	input  wire logic                       send_permit_n,
	output logic                            txd,
	output logic                            txd_oe,
	input  wire logic                       rxd,
	output logic                            accept_ready_n,
	output logic                            carrier_lock_indicator_n,
	input  wire logic                       spi_master,
	input  wire logic                       ss_n_in,
	output logic                            ss_n_out,
	output logic                            ss_n_oe,
	input  wire logic                       mosi_in,
	output logic                            mosi_out,
	output logic                            mosi_oe,
	input  wire logic                       miso_in,
	output logic                            miso_out,
	output logic                            miso_oe,
	input  wire logic                       sclk_in,
	output logic                            sclk_out,
	output logic                            sclk_oe,
	input  wire logic                       sleep,
	input  wire logic [1:0]                 txd_sleep_mode,
	input  wire logic [1:0]                 flow_sleep_mode,
	input  wire logic                       link_up,
	input  wire logic [hpf_pkg::DATA_W-1:0] tx_data,
	input  wire logic                       tx_valid,
	output logic                            tx_ready,
	output logic [hpf_pkg::DATA_W-1:0]      rx_data,
	output logic                            rx_valid,
	input  wire logic                       rx_ready
);
	import hpf_pkg::*;

	initial
	begin
		if (BAUD_CYC < 4 || SPI_HALF < 1)
			$error("hpf_host_port: divider too small");
	end

	// Pins from outside pass three flops; second and third must agree
	logic [2:0] s_rst, s_rts, s_rxd, s_ss, s_mosi, s_miso, s_sclk;
	logic       f_rts_reg, f_rxd_reg, f_ss_reg;
	logic       f_mosi_reg, f_miso_reg, f_sclk_reg;
	logic       srst;

	function automatic logic filt(input logic [2:0] s, input logic held);
		filt = (s[1] == s[2]) ? s[2] : held;
	endfunction

	// Reset pin passes the same sync chain; it clears all but the sync chains once flops two and three agree low
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_rst <= '0;
			s_rts <= '1;
			s_rxd <= '1;
			s_ss  <= '1;
			s_mosi <= '0;
			s_miso <= '0;
			s_sclk <= '0;
		end
		else if (ce)
		begin
			s_rst  <= {s_rst[1:0], reset_in_n};
			s_rts  <= {s_rts[1:0], send_permit_n};
			s_rxd  <= {s_rxd[1:0], rxd};
			s_ss   <= {s_ss[1:0], ss_n_in};
			s_mosi <= {s_mosi[1:0], mosi_in};
			s_miso <= {s_miso[1:0], miso_in};
			s_sclk <= {s_sclk[1:0], sclk_in};
		end
	end

	// Either the local reset or a low reset pin clears the port
	assign srst = rst || (s_rst[1] == s_rst[2] && !s_rst[2]);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			f_rts_reg  <= 1'b1;
			f_rxd_reg  <= 1'b1;
			f_ss_reg   <= 1'b1;
			f_mosi_reg <= 1'b0;
			f_miso_reg <= 1'b0;
			f_sclk_reg <= 1'b0;
		end
		else if (ce)
		begin
			f_rts_reg  <= filt(s_rts, f_rts_reg);
			f_rxd_reg  <= filt(s_rxd, f_rxd_reg);
			f_ss_reg   <= filt(s_ss, f_ss_reg);
			f_mosi_reg <= filt(s_mosi, f_mosi_reg);
			f_miso_reg <= filt(s_miso, f_miso_reg);
			f_sclk_reg <= filt(s_sclk, f_sclk_reg);
		end
	end

	// Transmitter: a new byte starts only while the host permits
	localparam int BW = $clog2(BAUD_CYC + 1);
	hpf_tx_t             tx_st_reg;
	logic [BW-1:0]       tx_cnt_reg;
	logic [2:0]          tx_bit_reg;
	logic [DATA_W-1:0]   tx_sh_reg;
	logic                txd_line_reg;
	logic                tx_tick;

	assign tx_tick  = (tx_cnt_reg == BW'(BAUD_CYC - 1));
	assign tx_ready = (tx_st_reg == TX_IDLE) && !f_rts_reg && !srst;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tx_st_reg    <= TX_IDLE;
			tx_cnt_reg   <= '0;
			tx_bit_reg   <= '0;
			tx_sh_reg    <= '0;
			txd_line_reg <= TXD_IDLE;
		end
		else if (ce)
		begin
			tx_cnt_reg <= (tx_st_reg == TX_IDLE || tx_tick) ? '0
				: tx_cnt_reg + BW'(1);
			case (tx_st_reg)
				TX_IDLE:
				begin
					txd_line_reg <= TXD_IDLE;
					// A byte in flight finishes; only new ones wait
					if (tx_valid && !f_rts_reg)
					begin
						tx_sh_reg <= tx_data;
						tx_st_reg <= TX_START;
						txd_line_reg <= 1'b0;
					end
				end
				TX_START:
					if (tx_tick)
					begin
						tx_st_reg    <= TX_DATA;
						tx_bit_reg   <= '0;
						txd_line_reg <= tx_sh_reg[0];
					end
				TX_DATA:
					if (tx_tick)
					begin
						if (tx_bit_reg == 3'h7)
						begin
							tx_st_reg    <= TX_STOP;
							txd_line_reg <= TXD_IDLE;
						end
						else
						begin
							tx_bit_reg   <= tx_bit_reg + 3'h1;
							tx_sh_reg    <= tx_sh_reg >> 1;
							txd_line_reg <= tx_sh_reg[1];
						end
					end
				TX_STOP:
					if (tx_tick)
						tx_st_reg <= TX_IDLE;
				default:
					tx_st_reg <= TX_IDLE;
			endcase
		end
	end

	// Receiver: samples mid-bit, pushes bytes into the FIFO
	hpf_rx_t             rx_st_reg;
	logic [BW-1:0]       rx_cnt_reg;
	logic [2:0]          rx_bit_reg;
	logic [DATA_W-1:0]   rx_sh_reg;
	logic                rx_push_reg;
	logic                fifo_in_ready;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rx_st_reg   <= RX_IDLE;
			rx_cnt_reg  <= '0;
			rx_bit_reg  <= '0;
			rx_sh_reg   <= '0;
			rx_push_reg <= 1'b0;
		end
		else if (ce)
		begin
			rx_push_reg <= 1'b0;
			rx_cnt_reg  <= rx_cnt_reg + BW'(1);
			case (rx_st_reg)
				RX_IDLE:
					if (!f_rxd_reg)
					begin
						rx_st_reg  <= RX_START;
						rx_cnt_reg <= '0;
					end
				RX_START:
					if (rx_cnt_reg == BW'(BAUD_CYC / 2))
					begin
						rx_cnt_reg <= '0;
						rx_bit_reg <= '0;
						rx_st_reg  <= f_rxd_reg ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (rx_cnt_reg == BW'(BAUD_CYC - 1))
					begin
						rx_cnt_reg <= '0;
						rx_sh_reg  <= {f_rxd_reg, rx_sh_reg[DATA_W-1:1]};
						rx_bit_reg <= rx_bit_reg + 3'h1;
						if (rx_bit_reg == 3'h7)
							rx_st_reg <= RX_STOP;
					end
				RX_STOP:
					if (rx_cnt_reg == BW'(BAUD_CYC - 1))
					begin
						// Framing error drops the byte
						rx_push_reg <= f_rxd_reg;
						rx_st_reg   <= RX_IDLE;
					end
				default:
					rx_st_reg <= RX_IDLE;
			endcase
		end
	end

	// Byte lost if the FIFO is full when the receiver pushes it
	hpf_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (srst),
		.ce        (ce),
		.in_data   (rx_sh_reg),
		.in_valid  (rx_push_reg),
		.in_ready  (fifo_in_ready),
		.out_data  (rx_data),
		.out_valid (rx_valid),
		.out_ready (rx_ready)
	);

	// SPI role and master clock/select generation
	localparam int SW = $clog2(SPI_HALF + 1);
	logic [SW-1:0] spi_cnt_reg;
	logic          sclk_gen_reg;

	always_ff @(posedge clk)
	begin
		if (srst || !spi_master)
		begin
			spi_cnt_reg  <= '0;
			sclk_gen_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (spi_cnt_reg == SW'(SPI_HALF - 1))
			begin
				spi_cnt_reg  <= '0;
				sclk_gen_reg <= !sclk_gen_reg;
			end
			else
				spi_cnt_reg <= spi_cnt_reg + SW'(1);
		end
	end

	// Pin outputs, all registered; sleep overrides txd by its own setting, flow and lock by a shared one
	logic flow_n;
	logic lock_n;
	assign flow_n = !fifo_in_ready;
	assign lock_n = link_up ? LOCK_ON_N : !LOCK_ON_N;

	function automatic logic slp_val(input logic [1:0] m, input logic act);
		case (m)
			SLP_LOW:  slp_val = 1'b0;
			SLP_HIGH: slp_val = 1'b1;
			default:  slp_val = act;
		endcase
	endfunction

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			txd                      <= 1'b0;
			txd_oe                   <= 1'b0;
			accept_ready_n           <= 1'b1;
			carrier_lock_indicator_n <= 1'b1;
			ss_n_out                 <= SS_IDLE_N;
			ss_n_oe                  <= 1'b0;
			mosi_out                 <= 1'b0;
			mosi_oe                  <= 1'b0;
			miso_out                 <= 1'b0;
			miso_oe                  <= 1'b0;
			sclk_out                 <= 1'b0;
			sclk_oe                  <= 1'b0;
		end
		else if (ce)
		begin
			// Released during reset so host can hold it low
			if (sleep)
			begin
				txd    <= slp_val(txd_sleep_mode, txd_line_reg);
				txd_oe <= (txd_sleep_mode != SLP_TRI);
			end
			else
			begin
				txd    <= txd_line_reg;
				txd_oe <= 1'b1;
			end
			accept_ready_n <= sleep
				? slp_val(flow_sleep_mode, flow_n) : flow_n;
			carrier_lock_indicator_n <= sleep
				? slp_val(flow_sleep_mode, lock_n) : lock_n;
			ss_n_oe  <= spi_master;
			mosi_oe  <= spi_master;
			sclk_oe  <= spi_master;
			miso_oe  <= !spi_master;
			ss_n_out <= spi_master ? 1'b0 : SS_IDLE_N;
			sclk_out <= sclk_gen_reg;
			mosi_out <= txd_line_reg;
			miso_out <= f_ss_reg ? 1'b0 : f_mosi_reg ^ f_sclk_reg;
		end
	end

	logic unused_in;
	assign unused_in = f_miso_reg;
endmodule // hpf_host_port

// file: hpf_host_model.sv
// Behavioural host controller on the serial lines
`timescale 1ns/1ps
module hpf_host_model #(
	parameter int BAUD = 8
) (
	input  wire logic clk,
	input  wire logic accept_ready_n,
	input  wire logic txd,
	input  wire logic txd_oe,
	output logic      rxd
);
	logic [7:0] rxq[$];
	logic [7:0] sh;

	initial rxd = 1'b1;

	// Frame: start low, data LSB first, stop high
	task automatic send(input logic [7:0] b, input logic obey);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		while (obey && accept_ready_n)
			@(posedge clk);
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk) rxd <= f[i];
			repeat (BAUD - 1) @(posedge clk);
		end
	endtask

	// Sampled mid-bit; frames with a bad stop bit are dropped
	always
	begin
		// Line is ours to hold low until the module drives it
		@(negedge txd iff txd_oe === 1'b1);
		repeat (BAUD / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BAUD) @(posedge clk);
			sh[i] = txd;
		end
		repeat (BAUD) @(posedge clk);
		if (txd === 1'b1 && txd_oe === 1'b1)
			rxq.push_back(sh);
	end
endmodule // hpf_host_model

// file: hpf_checker.sv
// Port assertions for the host port
`timescale 1ns/1ps
module hpf_checker
	import hpf_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       reset_in_n,
	input wire logic       send_permit_n,
	input wire logic       txd,
	input wire logic       txd_oe,
	input wire logic       accept_ready_n,
	input wire logic       carrier_lock_indicator_n,
	input wire logic       spi_master,
	input wire logic       ss_n_oe,
	input wire logic       mosi_oe,
	input wire logic       sclk_oe,
	input wire logic       miso_oe,
	input wire logic       sleep,
	input wire logic [1:0] flow_sleep_mode,
	input wire logic       link_up,
	input wire logic       tx_valid,
	input wire logic       tx_ready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_master_pins_tied: assert property (ss_n_oe == mosi_oe && mosi_oe == sclk_oe)
		else $error("master pin enables differ");
	a_miso_opposite: assert property (!(miso_oe && ss_n_oe))
		else $error("miso and master pins both driven");
	a_ss_role_rise: assert property ($rose(ss_n_oe) |-> $past(spi_master))
		else $error("master pins driven without master role");
	a_miso_role_rise: assert property ($rose(miso_oe) |-> !$past(spi_master))
		else $error("miso driven without slave role");
	a_permit_blocks: assert property (send_permit_n[*5] |-> !tx_ready)
		else $error("byte offered while permission withheld");
	a_start_bit_delay: assert property (tx_valid && tx_ready |=> ##1 !txd)
		else $error("start bit late");
	a_unlock_high: assert property ((!link_up && !sleep)[*2] |-> carrier_lock_indicator_n)
		else $error("lock shown without link");
	a_sleep_joint_high: assert property ((sleep && flow_sleep_mode == SLP_HIGH)[*3] |-> accept_ready_n && carrier_lock_indicator_n)
		else $error("joint sleep state not applied");
	a_pin_reset_off: assert property (!reset_in_n[*5] |-> !txd_oe && !ss_n_oe && !miso_oe)
		else $error("pin driven in reset");
	a_reset_release: assert property ($fell(rst) |-> !txd_oe && accept_ready_n)
		else $error("outputs not reset");

	c_tx_take: cover property (tx_valid && tx_ready);
	c_full: cover property ($rose(accept_ready_n));
	c_sleep_low: cover property (sleep && flow_sleep_mode == SLP_LOW);
endmodule // hpf_checker

// file: tb_top.sv
// Self-checking testbench for the host port
`timescale 1ns/1ps
module tb_top;
	import hpf_pkg::*;
	logic clk = 0, rst = 1, reset_in_n = 0, send_permit_n = 0, rxd;
	logic spi_master = 0, sleep = 0, link_up = 0, tx_valid = 0, rx_ready = 0;
	logic [1:0] txd_sleep_mode = 0, flow_sleep_mode = 0;
	logic [7:0] tx_data = 0, rx_data, d, q[$];
	logic txd, txd_oe, accept_ready_n, carrier_lock_indicator_n, tx_ready;
	logic rx_valid, ss_n_oe, mosi_oe, sclk_oe, miso_oe, h;
	logic ce = 1, ss_n_in = 1, mosi_in = 0, miso_in = 0, sclk_in = 0;
	logic ss_n_out, mosi_out, miso_out, sclk_out;
	int err_total = 0, n_tests = 0;

	hpf_host_port #(.BAUD_CYC(8), .SPI_HALF(2)) i_dut (.clk(clk), .rst(rst),
		.ce(ce), .reset_in_n(reset_in_n), .send_permit_n(send_permit_n),
		.txd(txd), .txd_oe(txd_oe), .rxd(rxd), .accept_ready_n(accept_ready_n),
		.carrier_lock_indicator_n(carrier_lock_indicator_n),
		.spi_master(spi_master), .ss_n_in(ss_n_in), .ss_n_out(ss_n_out),
		.ss_n_oe(ss_n_oe), .mosi_in(mosi_in), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out),
		.miso_oe(miso_oe), .sclk_in(sclk_in), .sclk_out(sclk_out),
		.sclk_oe(sclk_oe), .sleep(sleep), .txd_sleep_mode(txd_sleep_mode),
		.flow_sleep_mode(flow_sleep_mode), .link_up(link_up), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready));
	hpf_host_model #(.BAUD(8)) i_host (.clk(clk),
		.accept_ready_n(accept_ready_n), .txd(txd), .txd_oe(txd_oe), .rxd(rxd));

	initial forever #2.5 clk = ~clk;

	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task report_and_stop;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// {txd_oe, txd, accept_ready_n, lock}; tristate leaves txd unjudged
	function automatic logic [3:0] slp_exp(logic [1:0] t, logic [1:0] f,
		logic lk);
		logic a;
		a = (f == SLP_HIGH);
		return {t != SLP_TRI, t == SLP_HIGH || t == SLP_ACTIVE,
			(f == SLP_LOW || f == SLP_HIGH) ? {a, a} : {1'b0, !lk}};
	endfunction

	task automatic tx_byte(input logic [7:0] b);
		@(posedge clk);
		tx_data <= b;
		tx_valid <= 1'b1;
		h = 1'b0;
		while (!h)
		begin
			#1 h = tx_ready;
			@(posedge clk);
		end
		tx_valid <= 1'b0;
		for (int k = 0; k < 300 && i_host.rxq.size() == 0; k++)
			@(posedge clk);
		chk("tx byte", i_host.rxq.pop_front(), b);
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		report_and_stop;
	end

	initial
	begin
		void'($urandom(37456));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		reset_in_n <= 1'b1;
		repeat (8) @(posedge clk);
		for (int m = 0; m < 2; m++)
		begin
			@(posedge clk);
			spi_master <= m[0];
			{mosi_in, sclk_in, miso_in} <= 3'($urandom);
			repeat (3) @(posedge clk);
			#1 d = {2'h0, miso_out, ss_n_out,
				ss_n_oe, mosi_oe, sclk_oe, miso_oe};
			chk("spi", d, {3'h0, !m[0], {3{m[0]}}, !m[0]});
			h = sclk_out;
			repeat (2) @(posedge clk);
			#1 chk("sclk", {7'h00, sclk_out}, {7'h00, h ^ m[0]});
		end
		// Role change while frozen must not reach the pins
		@(posedge clk);
		ce <= 1'b0;
		spi_master <= 1'b0;
		repeat (4) @(posedge clk);
		#1 chk("ce hold", {6'h00, ss_n_oe, miso_oe}, 8'h02);
		@(posedge clk);
		ce <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("ce run", {6'h00, ss_n_oe, miso_oe}, 8'h01);
		for (int i = 0; i < 5; i++)
			tx_byte(i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($urandom));
		send_permit_n <= 1'b1;
		repeat (6) @(posedge clk);
		tx_data <= 8'h5A;
		tx_valid <= 1'b1;
		repeat (40) @(posedge clk);
		#1 chk("held", {6'h00, tx_ready, i_host.rxq.size() != 0}, 8'h00);
		@(posedge clk);
		send_permit_n <= 1'b0;
		tx_byte(8'h5A);
		for (int i = 0; i < 8; i++)
		begin
			q.push_back(8'($urandom));
			i_host.send(q[i], 1'b1);
		end
		repeat (20) @(posedge clk);
		#1 chk("full flag", {7'h00, accept_ready_n}, 8'h01);
		i_host.send(8'hA5, 1'b0);
		// Let the ignored byte reach the full FIFO before draining
		repeat (10) @(posedge clk);
		#1 chk("still full", {7'h00, accept_ready_n}, 8'h01);
		@(posedge clk);
		rx_ready <= 1'b1;
		foreach (q[i])
		begin
			h = 1'b0;
			while (!h)
			begin
				#1 h = rx_valid;
				d = rx_data;
				@(posedge clk);
			end
			chk("rx byte", d, q[i]);
		end
		rx_ready <= 1'b0;
		#1 chk("drained", {rx_valid, accept_ready_n}, 8'h00);
		for (int t = 0; t < 4; t++)
			for (int f = 0; f < 4; f++)
			begin
				@(posedge clk);
				link_up <= t[0];
				txd_sleep_mode <= 2'(t);
				flow_sleep_mode <= 2'(f);
				sleep <= 1'b1;
				repeat (4) @(posedge clk);
				#1 chk("sleep pins", {txd_oe, txd_oe & txd, accept_ready_n, carrier_lock_indicator_n}, {4'h0, slp_exp(2'(t), 2'(f), t[0])});
			end
		@(posedge clk);
		sleep <= 1'b0;
		reset_in_n <= 1'b0;
		repeat (6) @(posedge clk);
		#1 chk("pin reset", {txd_oe, ss_n_oe, miso_oe, accept_ready_n}, 8'h01);
		report_and_stop;
	end
endmodule // tb_top

bind hpf_host_port hpf_checker i_chk (.*);
